/* File: hw/isp_pkg.sv */
/*
  isp_pkg: constants shared by the sensor-side and master-side ends of the
  inertial sensor register port. Assumes a 200 MHz system clock on both ends.
*/
package isp_pkg;
  // ----------------------------------------------------------------
  // frame and address layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS     = 16;
  localparam int          RW_BIT         = 15;
  localparam int          ADDR_HI        = 14;
  localparam int          ADDR_LO        = 8;
  localparam int          BYTE_ADDRS     = 128;
  localparam int          WORD_ADDRS     = 64;
  localparam logic [15:0] CMD_BURST      = 16'h3E00;
  // ----------------------------------------------------------------
  // word indexes (byte address / 2)
  // ----------------------------------------------------------------
  localparam logic [5:0]  IDX_FLASH_WRITE_COUNTER  = 6'h00;
  localparam logic [5:0]  IDX_SUPPLY     = 6'h01;
  localparam logic [5:0]  IDX_ACCEL_X    = 6'h05;
  localparam logic [5:0]  IDX_AUX_ADC    = 6'h0B;
  localparam logic [5:0]  IDX_RW_FIRST   = 6'h0D;
  localparam logic [5:0]  IDX_RW_LAST    = 6'h1D;
  localparam logic [5:0]  IDX_SLEEP_CNT  = 6'h1D;
  localparam logic [5:0]  IDX_SAMPLE_PRD = 6'h1B;
  localparam logic [5:0]  IDX_GLOBAL_COMMAND_REGISTER   = 6'h1F;
  localparam int          BACKUP_BIT     = 3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_MISC_CTRL  = 16'h0006;
  localparam logic [15:0] RST_SAMPLE_PRD = 16'h0001;
  localparam logic [15:0] RST_SENS_AVG   = 16'h0402;
  localparam logic [5:0]  IDX_MISC_CTRL  = 6'h1A;
  localparam logic [5:0]  IDX_SENS_AVG   = 6'h1C;
  localparam logic [7:0]  LOW_POWER_PRD  = 8'h0A;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam real         SYS_CLK_MHZ    = 200.0;
  localparam real         SAMPLE_SPS     = 819.2;
  localparam int          SAMPLE_CYC     = int'(SYS_CLK_MHZ * 1.0e6 / SAMPLE_SPS);
  localparam real         BACKUP_MS      = 50.0;
  localparam int          BACKUP_CYC     = int'(BACKUP_MS * 1.0e3 * SYS_CLK_MHZ);
  localparam int          READY_CYC      = 8;
  localparam real         STALL_NORM_US  = 9.0;
  localparam real         STALL_LP_US    = 75.0;
  localparam int          STALL_NORM_CYC = int'(STALL_NORM_US * SYS_CLK_MHZ) + 1;
  localparam int          STALL_LP_CYC   = int'(STALL_LP_US * SYS_CLK_MHZ) + 1;
  localparam int          SCLK_HALF_NORM = 50;   // 2 MHz
  localparam int          SCLK_HALF_BST  = 100;  // 1 MHz
  localparam int          SCLK_HALF_LP   = 334;  // under 300 kHz
endpackage

/* File: hw/isp_link_if.sv */
/*
  isp_link_if: the five-wire serial link between master and sensor.
  Assumes the master drives clock and select; no tri-state on this link.
*/
`timescale 1ns/1ps
interface isp_link_if;
  logic sclk;     // serial clock, idles high
  logic cs_n;     // chip select, active low
  logic mosi;     // master to sensor data
  logic miso;     // sensor to master data
  logic drdy;     // data-ready pulse from sensor

  modport sensor (input sclk, input cs_n, input mosi, output miso, output drdy);
  modport master (output sclk, output cs_n, output mosi, input miso, input drdy);
endinterface

/* File: hw/isp_sensor.sv */
/*
  isp_sensor: sensor end of the register port. Samples run on their own,
  output words come in from the user side, config bytes are written by frames.
  Assumes the link pins are asynchronous to sys_clk and slow versus it.
*/
// Behaviour
// - drive output bit on falling serial clock
// - sample input bit on rising serial clock
// - sample continuously at 819.2 SPS unprompted
// - load outputs then pulse data ready
// - mode 3: idle high, rising capture
// - sixteen-bit MSB-first frames, master drives clock
// - master limits serial clock rate per mode
// - each word has two byte addresses
// - read: address frame, then data frame
// - command 0x0A00 returns accel X output
// - full duplex: next command during read data
// - write frame stores low byte at frame end
// - frame 0xA11F stores 0x1F at 0x21
// - global command bit 3 starts flash backup
// - flash backup lasts 50 ms
// - flash counter increments per backup
// - read-only registers ignore writes
// - 0x3E00 bursts supply through aux outputs
// - master keeps stall gap between frames
// - low power when sample period >= 0x0A
`timescale 1ns/1ps
module isp_sensor
  import isp_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,  // cycles per sample
  parameter int BACKUP_CYCLES = BACKUP_CYC   // flash backup duration
) (
  input  wire logic        sys_clk,          // 200 MHz clock
  input  wire logic        reset,            // async reset, high
  isp_link_if.sensor       link,             // serial link
  input  wire logic [15:0] meas_word [12],   // sample values, idx 1..11 used
  output logic             sample_strobe,    // one pulse per sample load
  output logic [7:0]       sample_period,    // current period setting
  output logic             low_power,        // low-power mode flag
  output logic             backup_busy,      // flash backup in progress
  output logic [15:0]      flash_count       // flash write counter
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sclk_s_r, cs_s_r, mosi_s_r;
  logic [2:0] sclk_s_nxt, cs_s_nxt, mosi_s_nxt;
  logic       sclk_q_r, cs_q_r, sclk_q_nxt, cs_q_nxt;
  always_comb begin
    sclk_s_nxt = {sclk_s_r[1:0], link.sclk};
    cs_s_nxt   = {cs_s_r[1:0], link.cs_n};
    mosi_s_nxt = {mosi_s_r[1:0], link.mosi};
    sclk_q_nxt = (sclk_s_r[1] == sclk_s_r[2]) ? sclk_s_r[2] : sclk_q_r;
    cs_q_nxt   = (cs_s_r[1] == cs_s_r[2]) ? cs_s_r[2] : cs_q_r;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sclk_s_r <= 3'h7;
      cs_s_r   <= 3'h7;
      mosi_s_r <= 3'h0;
      sclk_q_r <= 1'b1;
      cs_q_r   <= 1'b1;
    end else begin
      sclk_s_r <= sclk_s_nxt;
      cs_s_r   <= cs_s_nxt;
      mosi_s_r <= mosi_s_nxt;
      sclk_q_r <= sclk_q_nxt;
      cs_q_r   <= cs_q_nxt;
    end
  end
  wire sclk_new  = (sclk_s_r[1] == sclk_s_r[2]) ? sclk_s_r[2] : sclk_q_r;
  wire cs_new    = (cs_s_r[1] == cs_s_r[2]) ? cs_s_r[2] : cs_q_r;
  wire sclk_rise = !sclk_q_r && sclk_new && !cs_q_r;
  wire sclk_fall = sclk_q_r && !sclk_new && !cs_q_r;
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [15:0] regs_r [WORD_ADDRS];
  logic [15:0] regs_nxt [WORD_ADDRS];
  function automatic logic writable(input logic [5:0] idx);
    writable = (idx >= IDX_RW_FIRST && idx <= IDX_RW_LAST) || idx == IDX_GLOBAL_COMMAND_REGISTER;
  endfunction
  // ----------------------------------------------------------------
  // shift engine, sampling and backup
  // ----------------------------------------------------------------
  logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic [4:0]  bit_r, bit_nxt;
  logic        miso_r, miso_nxt;
  logic        burst_r, burst_nxt;
  logic [5:0]  bidx_r, bidx_nxt;
  logic [31:0] samp_cnt_r, samp_cnt_nxt, bk_cnt_r, bk_cnt_nxt;
  logic [3:0]  rdy_cnt_r, rdy_cnt_nxt;
  logic        bk_r, bk_nxt, strobe_r, strobe_nxt;
  logic [15:0] frame;
  logic [5:0]  fidx;
  always_comb begin
    regs_nxt     = regs_r;
    rx_nxt       = rx_r;
    tx_nxt       = tx_r;
    bit_nxt      = bit_r;
    miso_nxt     = miso_r;
    burst_nxt    = burst_r;
    bidx_nxt     = bidx_r;
    samp_cnt_nxt = samp_cnt_r + 32'h1;
    bk_cnt_nxt   = bk_cnt_r;
    bk_nxt       = bk_r;
    rdy_cnt_nxt  = (rdy_cnt_r != 4'h0) ? rdy_cnt_r - 4'h1 : 4'h0;
    strobe_nxt   = 1'b0;
    frame        = {rx_r[14:0], mosi_s_r[2]};
    fidx         = frame[ADDR_HI:ADDR_LO+1];
    if (samp_cnt_r >= 32'(SAMPLE_CYCLES - 1)) begin
      samp_cnt_nxt = 32'h0;
      for (int i = 1; i <= 11; i++) regs_nxt[i] = meas_word[i];
      strobe_nxt  = 1'b1;
      rdy_cnt_nxt = 4'(READY_CYC);
    end
    if (bk_r) begin
      if (bk_cnt_r >= 32'(BACKUP_CYCLES - 1)) begin
        bk_nxt = 1'b0;
        regs_nxt[IDX_FLASH_WRITE_COUNTER] = regs_r[IDX_FLASH_WRITE_COUNTER] + 16'h1;
      end else begin
        bk_cnt_nxt = bk_cnt_r + 32'h1;
      end
    end
    if (cs_q_r) begin
      bit_nxt = 5'h0;
    end
    if (sclk_fall && bit_r == 5'h0 && burst_r && bidx_r <= IDX_AUX_ADC) begin
      tx_nxt = regs_r[bidx_r];
      bidx_nxt = bidx_r + 6'h1;
    end
    if (sclk_fall) begin
      miso_nxt = tx_r[15];
      tx_nxt   = {tx_r[14:0], 1'b0};
      if (bit_r == 5'h0 && burst_r && bidx_r <= IDX_AUX_ADC) begin
        miso_nxt = regs_r[bidx_r][15];
        tx_nxt   = {regs_r[bidx_r][14:0], 1'b0};
      end
    end
    if (sclk_rise) begin
      rx_nxt  = frame;
      bit_nxt = bit_r + 5'h1;
      if (bit_r == 5'(FRAME_BITS - 1)) begin
        bit_nxt = 5'h0;
        if (burst_r && bidx_r <= IDX_AUX_ADC) begin
          bit_nxt = 5'h0;
        end else if (frame == CMD_BURST) begin
          burst_nxt = 1'b1;
          bidx_nxt  = IDX_SUPPLY;
        end else if (frame[RW_BIT]) begin
          burst_nxt = 1'b0;
          if (writable(fidx)) begin
            if (frame[ADDR_LO]) regs_nxt[fidx][15:8] = frame[7:0];
            else regs_nxt[fidx][7:0] = frame[7:0];
          end
          if (fidx == IDX_GLOBAL_COMMAND_REGISTER && !frame[ADDR_LO] && frame[BACKUP_BIT] && !bk_r) begin
            bk_nxt     = 1'b1;
            bk_cnt_nxt = 32'h0;
          end
          regs_nxt[IDX_GLOBAL_COMMAND_REGISTER] = 16'h0;
        end else begin
          burst_nxt = 1'b0;
          tx_nxt    = regs_r[fidx];
        end
        if (burst_r && bidx_r > IDX_AUX_ADC) burst_nxt = 1'b0;
      end
    end
    // select rises between burst words too; only a cut frame ends the burst
    if (cs_new && !cs_q_r && bit_r != 5'h0) burst_nxt = 1'b0;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < WORD_ADDRS; i++) regs_r[i] <= 16'h0;
      regs_r[IDX_MISC_CTRL]  <= RST_MISC_CTRL;
      regs_r[IDX_SAMPLE_PRD] <= RST_SAMPLE_PRD;
      regs_r[IDX_SENS_AVG]   <= RST_SENS_AVG;
      rx_r       <= 16'h0;
      tx_r       <= 16'h0;
      bit_r      <= 5'h0;
      miso_r     <= 1'b0;
      burst_r    <= 1'b0;
      bidx_r     <= 6'h0;
      samp_cnt_r <= 32'h0;
      bk_cnt_r   <= 32'h0;
      bk_r       <= 1'b0;
      rdy_cnt_r  <= 4'h0;
      strobe_r   <= 1'b0;
    end else begin
      regs_r     <= regs_nxt;
      rx_r       <= rx_nxt;
      tx_r       <= tx_nxt;
      bit_r      <= bit_nxt;
      miso_r     <= miso_nxt;
      burst_r    <= burst_nxt;
      bidx_r     <= bidx_nxt;
      samp_cnt_r <= samp_cnt_nxt;
      bk_cnt_r   <= bk_cnt_nxt;
      bk_r       <= bk_nxt;
      rdy_cnt_r  <= rdy_cnt_nxt;
      strobe_r   <= strobe_nxt;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.miso     = miso_r;
  assign link.drdy     = (rdy_cnt_r != 4'h0);
  assign sample_strobe = strobe_r;
  assign sample_period = regs_r[IDX_SAMPLE_PRD][7:0];
  assign low_power     = (regs_r[IDX_SAMPLE_PRD][7:0] >= LOW_POWER_PRD);
  assign backup_busy   = bk_r;
  assign flash_count   = regs_r[IDX_FLASH_WRITE_COUNTER];
endmodule

/* File: hw/isp_master.sv */
/*
  isp_master: master end. Takes one 16-bit frame per request, drives a
  mode 3 clock from sys_clk by division and returns the word shifted in.
  Assumes the user picks rate and gap by low_power and burst inputs.
*/
`timescale 1ns/1ps
module isp_master
  import isp_pkg::*;
(
  input  wire logic        sys_clk,     // 200 MHz clock
  input  wire logic        reset,       // async reset, high
  isp_link_if.master       link,        // serial link
  input  wire logic        req_valid,   // frame request
  output logic             req_ready,   // idle, request accepted
  input  wire logic [15:0] req_word,    // word to send
  input  wire logic        low_power,   // sensor in low-power mode
  input  wire logic        burst,       // part of a burst, gap of two half periods
  output logic             rsp_valid,   // one-cycle answer pulse
  output logic [15:0]      rsp_word,    // word received
  output logic             drdy_seen    // synchronised data-ready level
);
  typedef enum logic [1:0] {
    IM_IDLE = 2'b00,
    IM_SHIFT = 2'b01,
    IM_GAP = 2'b10
  } im_state_t;
  im_state_t   st_r, st_nxt;
  logic [15:0] tx_r, tx_nxt, rx_r, rx_nxt, rsp_r, rsp_nxt;
  logic [4:0]  bit_r, bit_nxt;
  logic [15:0] cnt_r, cnt_nxt, half_r, half_nxt;
  logic        sclk_r, sclk_nxt, cs_r, cs_nxt, bst_r, bst_nxt, lp_r, lp_nxt, vld_r, vld_nxt;
  logic [2:0]  miso_s_r, drdy_s_r;
  always_comb begin
    st_nxt = st_r; tx_nxt = tx_r; rx_nxt = rx_r; rsp_nxt = rsp_r;
    bit_nxt = bit_r; cnt_nxt = cnt_r; half_nxt = half_r;
    sclk_nxt = sclk_r; cs_nxt = cs_r; bst_nxt = bst_r; lp_nxt = lp_r; vld_nxt = 1'b0;
    unique case (st_r)
      IM_IDLE: begin
        if (req_valid) begin
          st_nxt = IM_SHIFT; tx_nxt = req_word; bit_nxt = 5'h0; cs_nxt = 1'b0;
          bst_nxt = burst; lp_nxt = low_power;
          half_nxt = low_power ? 16'(SCLK_HALF_LP) : burst ? 16'(SCLK_HALF_BST) : 16'(SCLK_HALF_NORM);
          cnt_nxt = half_nxt;
        end
      end
      IM_SHIFT: begin
        if (cnt_r != 16'h0) cnt_nxt = cnt_r - 16'h1;
        else begin
          cnt_nxt = half_r;
          if (bit_r == 5'(FRAME_BITS)) begin
            st_nxt = IM_GAP; cs_nxt = 1'b1; vld_nxt = 1'b1; rsp_nxt = rx_r;
            cnt_nxt = bst_r ? half_r + half_r : lp_r ? 16'(STALL_LP_CYC) : 16'(STALL_NORM_CYC);
          end else if (sclk_r) begin
            sclk_nxt = 1'b0;
            // data moves on the falling edge; the first bit already stands from select
            if (bit_r != 5'h0) tx_nxt = {tx_r[14:0], 1'b0};
          end else begin
            sclk_nxt = 1'b1; rx_nxt = {rx_r[14:0], miso_s_r[2]};
            bit_nxt = bit_r + 5'h1;
          end
        end
      end
      IM_GAP: begin
        if (cnt_r != 16'h0) cnt_nxt = cnt_r - 16'h1;
        else st_nxt = IM_IDLE;
      end
      default: st_nxt = IM_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r <= IM_IDLE; tx_r <= 16'h0; rx_r <= 16'h0; rsp_r <= 16'h0; bit_r <= 5'h0;
      cnt_r <= 16'h0; half_r <= 16'h0; sclk_r <= 1'b1; cs_r <= 1'b1;
      bst_r <= 1'b0; lp_r <= 1'b0; vld_r <= 1'b0; miso_s_r <= 3'h0; drdy_s_r <= 3'h0;
    end else begin
      st_r <= st_nxt; tx_r <= tx_nxt; rx_r <= rx_nxt; rsp_r <= rsp_nxt; bit_r <= bit_nxt;
      cnt_r <= cnt_nxt; half_r <= half_nxt; sclk_r <= sclk_nxt; cs_r <= cs_nxt;
      bst_r <= bst_nxt; lp_r <= lp_nxt; vld_r <= vld_nxt;
      miso_s_r <= {miso_s_r[1:0], link.miso};
      drdy_s_r <= {drdy_s_r[1:0], link.drdy};
    end
  end
  assign link.sclk = sclk_r;
  assign link.cs_n = cs_r;
  assign link.mosi = tx_r[15];
  assign req_ready = (st_r == IM_IDLE);
  assign rsp_valid = vld_r;
  assign rsp_word  = rsp_r;
  assign drdy_seen = drdy_s_r[2] & drdy_s_r[1];
endmodule

/* File: testbench/isp_link_props.sv */
/*
  isp_link_props: concurrent checks on the serial link between the two ends.
  Assumes it sees the interface signals as plain inputs and the sensor's
  sample count parameter handed on by the bench.
*/
`timescale 1ns/1ps
module isp_link_props #(
  parameter int SAMPLE_CYCLES = 400  // cycles per sample
) (
  input wire logic sys_clk,  // 200 MHz clock
  input wire logic reset,    // async reset, high
  input wire logic sclk,     // serial clock
  input wire logic cs_n,     // chip select, low
  input wire logic mosi,     // master data
  input wire logic miso,     // sensor data
  input wire logic drdy      // data-ready pulse
);
  logic        sclk_d_r;
  logic        drdy_d_r;
  logic        smp_seen_r;
  logic [4:0]  rise_cnt_r;
  logic [11:0] half_cnt_r;
  logic [11:0] gap_cnt_r;
  logic [19:0] smp_cnt_r;

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  // saturating, so a long idle never wraps into a false short gap
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sclk_d_r   <= 1'b1;
      drdy_d_r   <= 1'b0;
      smp_seen_r <= 1'b0;
      rise_cnt_r <= 5'h00;
      half_cnt_r <= 12'h000;
      gap_cnt_r  <= 12'hFFF;
      smp_cnt_r  <= 20'h00000;
    end else begin
      sclk_d_r   <= sclk;
      drdy_d_r   <= drdy;
      rise_cnt_r <= cs_n ? 5'h00 : rise_cnt_r + 5'(sclk && !sclk_d_r);
      half_cnt_r <= (sclk != sclk_d_r) ? 12'h000 : half_cnt_r + 12'(half_cnt_r != 12'hFFF);
      gap_cnt_r  <= !cs_n ? 12'h000 : gap_cnt_r + 12'(gap_cnt_r != 12'hFFF);
      smp_cnt_r  <= (drdy && !drdy_d_r) ? 20'h00000 : smp_cnt_r + 20'h00001;
      if (drdy && !drdy_d_r) begin
        smp_seen_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  miso_on_fall_a: assert property (!cs_n && $past(!cs_n, 8) && $changed(miso) |-> !sclk)
    else $error("sensor data changed while serial clock high");
  mosi_on_fall_a: assert property (!cs_n && $past(!cs_n) && $changed(mosi) |-> !sclk)
    else $error("master data changed while serial clock high");
  sample_rate_a: assert property ($rose(drdy) && smp_seen_r |->
                                  smp_cnt_r inside {[SAMPLE_CYCLES-3:SAMPLE_CYCLES+1]})
    else $error("data-ready spacing off");
  ready_pulse_a: assert property ($rose(drdy) |-> drdy [*8] ##1 !drdy)
    else $error("data-ready pulse width wrong");
  sclk_idle_a: assert property (cs_n |-> sclk)
    else $error("serial clock not high outside frame");
  frame_bits_a: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
    else $error("frame without sixteen rising edges");
  sclk_rate_a: assert property (!cs_n && sclk != sclk_d_r |-> half_cnt_r >= 12'd48)
    else $error("serial clock half period too short");
  stall_gap_a: assert property ($fell(cs_n) |-> gap_cnt_r >= 12'd199)
    else $error("gap between frames too short");
  select_lead_a: assert property ($fell(cs_n) |-> sclk [*8])
    else $error("serial clock moved too soon after select");

  cover property ($rose(drdy));
  cover property ($rose(cs_n) && rise_cnt_r == 5'h10);
  cover property ($fell(cs_n) && gap_cnt_r < 12'd400);
endmodule

/* File: testbench/test_inertial_sensor_spi_register_port.sv */
/*
  test_inertial_sensor_spi_register_port: drives the master end with read and
  write frames and checks the words that the sensor end returns.
  Assumes the design package and short sample and backup counts.
*/
`timescale 1ns/1ps
module test_inertial_sensor_spi_register_port;
  import isp_pkg::*;
  logic        sys_clk, reset, req_valid, req_ready, burst, lp, rsp_valid, drdy_seen, strobe, busy;
  logic [15:0] req_word, rsp_word, fcnt, rd;
  logic [15:0] meas [12];
  logic [7:0]  prd;
  int          fail_count, total_checks, n, busy_cyc;

  // backup length counted on every clock, as the backup starts before the frame's response arrives
  always @(posedge sys_clk) begin
    if (reset) busy_cyc <= 0;
    else if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
  end

  isp_link_if link ();
  isp_sensor #(.SAMPLE_CYCLES(400), .BACKUP_CYCLES(50)) u_isp_sensor (.sys_clk(sys_clk), .reset(reset),
    .link(link), .meas_word(meas), .sample_strobe(strobe), .sample_period(prd), .low_power(lp),
    .backup_busy(busy), .flash_count(fcnt));
  isp_master u_isp_master (.sys_clk(sys_clk), .reset(reset), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_word(req_word), .low_power(lp), .burst(burst), .rsp_valid(rsp_valid),
    .rsp_word(rsp_word), .drdy_seen(drdy_seen));
  isp_link_props #(.SAMPLE_CYCLES(400)) u_isp_link_props (.sys_clk(sys_clk), .reset(reset),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .drdy(link.drdy));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one frame; the request stays up until the edge that accepts it
  task automatic xfer(input logic [15:0] w, input logic b);
    @(negedge sys_clk);
    n = 0;
    while (req_ready !== 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    req_valid = 1'b1;
    req_word = w;
    burst = b;
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    rd = rsp_word;
    if (n >= 20000) begin
      fail_count++;
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    #700000;
    fail_count++;
    end_of_test;
  end

  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_word = 16'h0000;
    burst = 1'b0;
    fail_count = 0;
    total_checks = 0;
    for (int i = 0; i < 12; i++) begin
      meas[i] = 16'(16'h0111 * i + 16'h00C3);
    end
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    n = 0;
    while (drdy_seen !== 1'b1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    chk({15'h0000, drdy_seen}, 16'h0001);
    chk({8'h00, prd}, {8'h00, RST_SAMPLE_PRD[7:0]});
    xfer(16'h0A00, 1'b0);
    xfer(16'h3600, 1'b0);
    chk(rd, meas[5]);
    xfer(16'hA11F, 1'b0);
    chk(rd, RST_SAMPLE_PRD);
    xfer(16'hA0C4, 1'b0);
    xfer(16'hBC55, 1'b0);
    xfer(16'h2100, 1'b0);
    xfer(16'h3C00, 1'b0);
    chk(rd, 16'h1FC4);
    xfer(16'hBE08, 1'b0);
    chk(rd, 16'h0000);
    n = 0;
    while (busy !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(busy_cyc), 16'd50);
    chk(fcnt, 16'h0001);
    xfer(16'h0000, 1'b0);
    xfer(16'hB60A, 1'b0);
    chk(rd, 16'h0001);
    repeat (8) @(negedge sys_clk);
    chk({prd, 7'h00, lp}, 16'h0A01);
    // boundary value back to normal mode; this frame runs at the slow rate
    xfer(16'hB609, 1'b0);
    repeat (8) @(negedge sys_clk);
    chk({prd, 7'h00, lp}, 16'h0900);
    xfer(CMD_BURST, 1'b1);
    for (int i = 1; i < 11; i++) begin
      xfer(16'h0000, 1'b1);
      chk(rd, meas[i]);
    end
    xfer(16'h0000, 1'b1);
    chk(rd, meas[11]);
    end_of_test;
  end
endmodule
